// *** core/cmbps_pkg.sv ***
// Package for the CAN message buffer length, priority and stamp block.
// Assumes a 32-bit APB register bus with byte addresses on paddr.
package cmbps_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL      = 8'h00; // Mode and stamp enable.
    localparam logic [7:0] OFS_TX_FLAG   = 8'h04; // tx_flag_register.
    localparam logic [7:0] OFS_TX_SELECT = 8'h08; // tx_buffer_select.
    localparam logic [7:0] OFS_LENGTH    = 8'h0C; // msg_length_code.
    localparam logic [7:0] OFS_PRIORITY  = 8'h10; // tx_local_priority.
    localparam logic [7:0] OFS_STAMP_HI  = 8'h14; // stamp_high_byte.
    localparam logic [7:0] OFS_STAMP_LO  = 8'h18; // stamp_low_byte.
    localparam logic [7:0] OFS_STATUS    = 8'h1C; // Scheduler state.
    localparam logic [7:0] OFS_RX_STAMP  = 8'h20; // Last receive stamp.
    localparam logic [7:0] OFS_TIMER     = 8'h24; // Live stamping timer.

    // ------------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------------
    localparam int CTRL_INIT_BIT   = 0;  // Initialization mode.
    localparam int CTRL_TIME_BIT   = 1;  // Time stamping enable.
    localparam int LEN_CODE_W      = 4;  // length_code in bits 3:0.
    localparam int LOCAL_PRIORITY_VALUE_W          = 8;  // local_priority_value.
    localparam int STAMP_W         = 16; // Stamping timer width.
    localparam int STAT_VALID_BIT  = 0;  // A buffer is chosen.
    localparam int STAT_INDEX_LSB  = 1;  // Chosen index, two bits.
    localparam int STAT_COUNT_LSB  = 4;  // Chosen byte count, four bits.
    localparam int IDX_W           = 2;  // Buffer index width.

    // ------------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------------
    localparam logic        RST_INIT      = 1'b1;
    localparam logic        RST_TIME      = 1'b0;
    localparam logic [7:0]  RST_PRIORITY  = 8'h00;
    localparam logic [3:0]  RST_LEN_CODE  = 4'h0;
    localparam logic [15:0] RST_STAMP     = 16'h0000;
    localparam logic [3:0]  MAX_DATA_BYTES = 4'h8;

    // Data byte count sent for a length code; remote frames send none.
    function automatic logic [3:0] byte_count(input logic [3:0] code,
                                              input logic       remote);
        if (remote)
        begin
            byte_count = 4'h0;
        end
        else if (code > MAX_DATA_BYTES)
        begin
            byte_count = MAX_DATA_BYTES;
        end
        else
        begin
            byte_count = code;
        end
    endfunction

endpackage

// *** core/cmbps_sel_if.sv ***
// Carrier between the buffer store and the priority selector.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
interface cmbps_sel_if #(
    parameter int NUM_BUF = 3
);
    logic [NUM_BUF-1:0] pending;            // Buffer empty flag cleared.
    logic [7:0]         local_priority_value [NUM_BUF];     // Local priority per buffer.
    logic               valid;              // Some buffer is pending.
    logic [1:0]         index;              // Winning buffer index.

    modport store (output pending, output local_priority_value, input valid, input index);
    modport select (input pending, input local_priority_value, output valid, output index);
endinterface

// *** core/cmbps_local_priority_value_select.sv ***
// Combinational transmit priority selector.
// Assumes pending and priorities are stable registered values.
`timescale 1ns/1ps
module cmbps_local_priority_value_select #(
    parameter int NUM_BUF = 3
) (
    cmbps_sel_if.select sel    // Pending set in, winner out.
);

    // ------------------------------------------------------------------
    // Smallest value wins
    // ------------------------------------------------------------------
    // A strict less-than keeps the earlier index on a tie, so the lowest
    // index wins among equal priorities without a second pass.
    always_comb
    begin
        logic [7:0] best;
        best      = 8'hFF;
        sel.valid = 1'b0;
        sel.index = 2'h0;
        for (int i = 0; i < NUM_BUF; i++)
        begin
            if (sel.pending[i] && (!sel.valid || sel.local_priority_value[i] < best))
            begin
                best      = sel.local_priority_value[i];
                sel.valid = 1'b1;
                sel.index = 2'(i);
            end
        end
    end

endmodule

// *** core/cmbps_top.sv ***
// Notes on behaviour
// - Length code held in bits 3:0.
// - Data frame codes 0 to 8 count bytes.
// - Remote frame keeps code, sends no data.
// - Eight-bit priority, smaller value ranks higher.
// - Buffers with cleared empty flag compete.
// - Smallest priority value is sent next.
// - Ties go to the lowest index.
// - Acknowledged message gets stamp when enabled.
// - Stamp taken at acknowledge delimiter sample.
// - Timer free runs on bit clock.
// - Timer wraps silently.
// - Timer held zero in initialization mode.
// - Stamp registers read only; writes ignored.
// - Three independent transmit buffers.
// - Software clears empty; device sets after sending.
//
// Top of the transmit buffer length, priority and stamp block.
// Assumes an APB master on pclk and a CAN protocol engine that gives
// single-cycle pulses synchronous to pclk.
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module cmbps_top #(
    parameter int NUM_BUF = 3  // Transmit buffer count.
) (
    input  wire logic              pclk,           // Controller clock.
    input  wire logic              presetn,        // Async reset, low.
    input  wire logic              psel,           // APB select.
    input  wire logic              penable,        // APB access phase.
    input  wire logic              pwrite,         // APB write.
    input  wire logic [7:0]        paddr,          // APB byte address.
    input  wire logic [31:0]       pwdata,         // APB write data.
    output logic      [31:0]       prdata,         // APB read data.
    output logic                   pready,         // APB ready.
    output logic                   pslverr,        // APB error.
    input  wire logic              bit_tick,       // CAN bit clock pulse.
    input  wire logic              sof_req,        // Arbitration about now.
    input  wire logic              tx_done,        // Tx acked, delimiter.
    input  wire logic              rx_ack_delim,   // Rx acked, delimiter.
    input  wire logic [NUM_BUF-1:0] tx_remote,     // Remote flag per buffer.
    output logic                   tx_valid,       // A buffer is chosen.
    output logic      [1:0]        tx_index,       // Chosen buffer.
    output logic      [3:0]        tx_length_code, // Code put on the bus.
    output logic      [3:0]        tx_byte_count,  // Data bytes to send.
    output logic                   init_mode       // Initialization mode.
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    // The index fields are two bits wide, so at most four buffers fit.
    generate
        if (NUM_BUF < 2 || NUM_BUF > 4)
        begin : g_bad_num_buf
            $error("NUM_BUF must lie between 2 and 4");
        end
    endgenerate

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic                          init_r;
    logic                          time_en_r;
    logic [NUM_BUF-1:0]            empty_r;
    logic [NUM_BUF-1:0]            select_r;
    logic [3:0]                    len_r      [NUM_BUF];
    logic [7:0]                    local_priority_value_r     [NUM_BUF];
    logic [15:0]                   stamp_r    [NUM_BUF];
    logic [15:0]                   rx_stamp_r;
    logic [15:0]                   timer_r;
    logic                          active_r;
    logic [1:0]                    active_idx_r;
    logic [3:0]                    active_cnt_r;
    logic [31:0]                   prdata_r;
    logic                          pready_r;
    logic                          pslverr_r;
    logic [31:0]                   rd_nxt;
    logic                          hit_nxt;
    logic                          wr_acc;
    logic [1:0]                    sel_idx;
    logic                          sel_ok;
    logic [NUM_BUF-1:0]            select_nxt;
    logic [NUM_BUF-1:0]            done_set;

    cmbps_sel_if #(.NUM_BUF(NUM_BUF)) sel ();

    cmbps_local_priority_value_select #(.NUM_BUF(NUM_BUF)) u_select (
        .sel (sel.select)
    );

    // Feed the selector with buffers software has marked ready.
    always_comb
    begin
        sel.pending = ~empty_r;
        for (int i = 0; i < NUM_BUF; i++)
        begin
            sel.local_priority_value[i] = local_priority_value_r[i];
        end
    end

    // ------------------------------------------------------------------
    // Selected buffer decode
    // ------------------------------------------------------------------
    // The window follows the one-hot select; access to per-buffer fields
    // is only granted while that buffer is also empty.
    always_comb
    begin
        sel_idx = 2'h0;
        for (int i = NUM_BUF - 1; i >= 0; i--)
        begin
            if (select_r[i])
            begin
                sel_idx = 2'(i);
            end
        end
        sel_ok = |(select_r & empty_r);
    end

    // A select write keeps only the lowest requested buffer that is free.
    always_comb
    begin
        logic [NUM_BUF-1:0] req;
        req        = pwdata[NUM_BUF-1:0] & empty_r;
        select_nxt = req & (~req + 1'b1);
    end

    assign wr_acc   = psel & penable & pready_r & pwrite;
    assign done_set = (tx_done && active_r) ?
                      NUM_BUF'(1) << active_idx_r : '0;

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            init_r    <= cmbps_pkg::RST_INIT;
            time_en_r <= cmbps_pkg::RST_TIME;
        end
        else if (wr_acc && paddr == cmbps_pkg::OFS_CTRL)
        begin
            init_r    <= pwdata[cmbps_pkg::CTRL_INIT_BIT];
            time_en_r <= pwdata[cmbps_pkg::CTRL_TIME_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Empty flags and buffer select
    // ------------------------------------------------------------------
    // Writing one clears a flag to queue the buffer; a completion in the
    // same cycle wins so that a finished buffer is never lost.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            empty_r <= '1;
        end
        else
        begin
            logic [NUM_BUF-1:0] clr;
            clr = (wr_acc && paddr == cmbps_pkg::OFS_TX_FLAG) ?
                  pwdata[NUM_BUF-1:0] : '0;
            empty_r <= (empty_r & ~clr) | done_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            select_r <= '0;
        end
        else if (wr_acc && paddr == cmbps_pkg::OFS_TX_SELECT)
        begin
            select_r <= select_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Length code and local priority per buffer
    // ------------------------------------------------------------------
    // Priority writes outside the allowed window are dropped silently.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NUM_BUF; i++)
            begin
                len_r[i]  <= cmbps_pkg::RST_LEN_CODE;
                local_priority_value_r[i] <= cmbps_pkg::RST_PRIORITY;
            end
        end
        else if (wr_acc && sel_ok)
        begin
            if (paddr == cmbps_pkg::OFS_LENGTH)
            begin
                len_r[sel_idx] <= pwdata[cmbps_pkg::LEN_CODE_W-1:0];
            end
            if (paddr == cmbps_pkg::OFS_PRIORITY)
            begin
                local_priority_value_r[sel_idx] <= pwdata[cmbps_pkg::LOCAL_PRIORITY_VALUE_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Stamping timer and stamps
    // ------------------------------------------------------------------
    // The timer wraps with no overflow flag; nothing downstream needs one.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timer_r <= cmbps_pkg::RST_STAMP;
        end
        else if (init_r)
        begin
            timer_r <= cmbps_pkg::RST_STAMP;
        end
        else if (bit_tick)
        begin
            timer_r <= timer_r + 16'h0001;
        end
    end

    // Stamps land on the delimiter pulse; no bus write reaches them.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NUM_BUF; i++)
            begin
                stamp_r[i] <= cmbps_pkg::RST_STAMP;
            end
            rx_stamp_r <= cmbps_pkg::RST_STAMP;
        end
        else if (time_en_r)
        begin
            if (tx_done && active_r)
            begin
                stamp_r[active_idx_r] <= timer_r;
            end
            if (rx_ack_delim)
            begin
                rx_stamp_r <= timer_r;
            end
        end
    end

    // ------------------------------------------------------------------
    // Scheduling
    // ------------------------------------------------------------------
    // Each arbitration picks afresh, so a retry after an error may send a
    // different buffer if software queued a better one meanwhile.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            active_r     <= 1'b0;
            active_idx_r <= 2'h0;
            active_cnt_r <= 4'h0;
        end
        else if (init_r || (tx_done && active_r))
        begin
            active_r <= 1'b0;
        end
        else if (sof_req)
        begin
            active_r     <= sel.valid;
            active_idx_r <= sel.index;
            active_cnt_r <= cmbps_pkg::byte_count(len_r[sel.index],
                                                  tx_remote[sel.index]);
        end
    end

    // Outputs to the protocol engine, straight from flip-flops.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_valid       <= 1'b0;
            tx_index       <= 2'h0;
            tx_length_code <= 4'h0;
            tx_byte_count  <= 4'h0;
            init_mode      <= cmbps_pkg::RST_INIT;
        end
        else
        begin
            tx_valid       <= active_r;
            tx_index       <= active_idx_r;
            tx_length_code <= len_r[active_idx_r];
            tx_byte_count  <= active_cnt_r;
            init_mode      <= init_r;
        end
    end

    // ------------------------------------------------------------------
    // APB read decode
    // ------------------------------------------------------------------
    always_comb
    begin
        rd_nxt  = 32'h0000_0000;
        hit_nxt = 1'b1;
        unique case (paddr)
            cmbps_pkg::OFS_CTRL:
            begin
                rd_nxt[cmbps_pkg::CTRL_INIT_BIT] = init_r;
                rd_nxt[cmbps_pkg::CTRL_TIME_BIT] = time_en_r;
            end
            cmbps_pkg::OFS_TX_FLAG:   rd_nxt[NUM_BUF-1:0] = empty_r;
            cmbps_pkg::OFS_TX_SELECT: rd_nxt[NUM_BUF-1:0] = select_r;
            cmbps_pkg::OFS_LENGTH:
                if (sel_ok) rd_nxt[3:0] = len_r[sel_idx];
            cmbps_pkg::OFS_PRIORITY:
                if (sel_ok) rd_nxt[7:0] = local_priority_value_r[sel_idx];
            cmbps_pkg::OFS_STAMP_HI:
                if (sel_ok) rd_nxt[7:0] = stamp_r[sel_idx][15:8];
            cmbps_pkg::OFS_STAMP_LO:
                if (sel_ok) rd_nxt[7:0] = stamp_r[sel_idx][7:0];
            cmbps_pkg::OFS_STATUS:
            begin
                rd_nxt[cmbps_pkg::STAT_VALID_BIT] = active_r;
                rd_nxt[cmbps_pkg::STAT_INDEX_LSB +: 2] = active_idx_r;
                rd_nxt[cmbps_pkg::STAT_COUNT_LSB +: 4] = active_cnt_r;
            end
            cmbps_pkg::OFS_RX_STAMP:  rd_nxt[15:0] = rx_stamp_r;
            cmbps_pkg::OFS_TIMER:     rd_nxt[15:0] = timer_r;
            default:                  hit_nxt = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // APB handshake
    // ------------------------------------------------------------------
    // Ready rises one cycle after setup so every output comes from a
    // flip-flop; this costs exactly one wait-free access cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r  <= psel & ~penable;
            pslverr_r <= psel & ~penable & ~hit_nxt;
            if (psel && !penable && !pwrite)
            begin
                prdata_r <= rd_nxt;
            end
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

endmodule

// *** tb/cmbps_chk.sv ***
// Checker for the transmit length, priority and stamp block.
// Assumes it is bound to cmbps_top and sees that module's ports only.
`timescale 1ns/1ps
module cmbps_chk #(
    parameter int NUM_BUF = 3  // Buffer count.
) (
    input wire logic               pclk,           // Clock.
    input wire logic               presetn,        // Reset, low.
    input wire logic               psel,           // APB select.
    input wire logic               penable,        // APB access.
    input wire logic               pready,         // APB ready.
    input wire logic               pslverr,        // APB error.
    input wire logic               sof_req,        // Arbitration.
    input wire logic               tx_done,        // Tx acked.
    input wire logic [NUM_BUF-1:0] tx_remote,      // Remote flags.
    input wire logic               tx_valid,       // Chosen.
    input wire logic [1:0]         tx_index,       // Chosen buffer.
    input wire logic [3:0]         tx_length_code, // Code.
    input wire logic [3:0]         tx_byte_count,  // Byte count.
    input wire logic               init_mode       // Init mode.
);
    // ------------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // The bus answers one cycle after setup.
    a_apb_answer: assert property ((psel && !penable) |=> pready)
        else $error("no pready after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_slverr_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    // Remote frames carry no data bytes.
    a_count_remote: assert property (
        (tx_valid && tx_remote[tx_index]) |-> tx_byte_count == 4'h0)
        else $error("remote frame has data");
    a_count_data: assert property (
        (tx_valid && !tx_remote[tx_index]) |-> tx_byte_count ==
        ((tx_length_code > 4'h8) ? 4'h8 : tx_length_code))
        else $error("data byte count wrong");
    // A choice only follows an arbitration request.
    a_sof_cause: assert property ($rose(tx_valid) |-> $past(sof_req, 2))
        else $error("choice without arbitration");
    a_done_release: assert property (
        (tx_done && tx_valid) |=> ##1 !tx_valid)
        else $error("choice kept after ack");
    a_init_clear: assert property ((init_mode ##1 init_mode) |-> !tx_valid)
        else $error("choice held in init mode");
    // The choice holds between requests.
    a_choice_stable: assert property (
        (!sof_req && !$past(sof_req) && !tx_done && !$past(tx_done)
         && !init_mode) |=> (!tx_valid || $stable(tx_index)))
        else $error("choice drifted");
endmodule

bind cmbps_top cmbps_chk #(.NUM_BUF(NUM_BUF)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .sof_req(sof_req),
    .tx_done(tx_done), .tx_remote(tx_remote), .tx_valid(tx_valid),
    .tx_index(tx_index), .tx_length_code(tx_length_code),
    .tx_byte_count(tx_byte_count), .init_mode(init_mode)
);

// *** tb/cmbps_link_model.sv ***
// Protocol engine stand-in that paces frames for the block.
// Assumes every pulse lasts one pclk cycle.
`timescale 1ns/1ps
module cmbps_link_model (
    input  wire logic pclk,         // Clock.
    input  wire logic tx_valid,     // Choice made.
    output logic      bit_tick,     // Bit clock pulse.
    output logic      sof_req,      // Start of frame.
    output logic      tx_done,      // Own frame acked.
    output logic      rx_ack_delim  // Received frame acked.
);
    // Idle between frames: no pulses at all.
    initial
    begin
        {bit_tick, sof_req, tx_done, rx_ack_delim} = 4'h0;
    end

    // Bit clock ticks.
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge pclk);
            bit_tick <= 1'b1;
            @(posedge pclk);
            bit_tick <= 1'b0;
        end
    endtask

    // Arbitration pulse, then a bounded wait for a choice.
    task automatic arbitrate(output logic ok);
        int n = 0;
        @(posedge pclk);
        sof_req <= 1'b1;
        @(posedge pclk);
        sof_req <= 1'b0;
        while (tx_valid !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        ok = (tx_valid === 1'b1);
    endtask

    // Ack delimiter pulse, own or received frame.
    task automatic ack(input logic own);
        @(posedge pclk);
        if (own)
            tx_done <= 1'b1;
        else
            rx_ack_delim <= 1'b1;
        @(posedge pclk);
        {tx_done, rx_ack_delim} <= 2'b00;
    endtask
endmodule

// *** tb/cmbps_top_bench.sv ***
// Self-checking bench for the length, priority and stamp block.
// Assumes the APB timing and register map of the package.
`timescale 1ns/1ps
module cmbps_top_bench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        bit_tick, sof_req, tx_done, rx_ack_delim, tx_valid;
    logic        init_mode, e, ok;
    logic [2:0]  tx_remote, gone;
    logic [1:0]  tx_index;
    logic [3:0]  tx_length_code, tx_byte_count;
    int          errors, cmp_count, tcount, i, k;
    logic [3:0]  code_t [3] = '{4'hA, 4'h3, 4'h8};
    logic [7:0]  local_priority_value_t [3] = '{8'h20, 8'h10, 8'h10};
    logic [1:0]  ord_t [3] = '{2'd1, 2'd2, 2'd0};

    cmbps_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bit_tick(bit_tick), .sof_req(sof_req),
        .tx_done(tx_done), .rx_ack_delim(rx_ack_delim),
        .tx_remote(tx_remote), .tx_valid(tx_valid), .tx_index(tx_index),
        .tx_length_code(tx_length_code), .tx_byte_count(tx_byte_count),
        .init_mode(init_mode));
    cmbps_link_model lm (.pclk(pclk), .tx_valid(tx_valid),
        .bit_tick(bit_tick), .sof_req(sof_req), .tx_done(tx_done),
        .rx_ack_delim(rx_ack_delim));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        cmp_count++;
        if (s !== x)
        begin
            errors++;
            $display("FAIL %0t: got %h want %h", $time, s, x);
        end
    endtask

    // One APB transfer; the request stands until pready is sampled.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Clock, reset and watchdog
    // ------------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // A hang counts as a mismatch; tests need under a thousand cycles.
    initial
    begin
        repeat (20000) @(posedge pclk);
        errors++;
        print_verdict();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {errors, cmp_count, tcount} = '0;
        gone = 3'b000;
        tx_remote = 3'b000;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // Reset state, unmapped access and frozen timer.
        rd(cmbps_pkg::OFS_CTRL, 32'h1);
        rd(cmbps_pkg::OFS_TX_FLAG, 32'h7);
        chk(init_mode, 1'b1);
        apb(1'b0, 8'hFC, 32'h0);
        chk(e, 1'b1);
        chk(q, 32'h0);
        lm.tick(4);
        rd(cmbps_pkg::OFS_TIMER, 32'h0);
        $display("test reset done");
        // Leave initialization with stamping on; timer counts ticks.
        apb(1'b1, cmbps_pkg::OFS_CTRL, 32'h2);
        lm.tick(300);
        tcount = 300;
        rd(cmbps_pkg::OFS_TIMER, 32'(tcount));
        $display("test timer done");
        // Load each buffer through the select window.
        for (i = 0; i < 3; i++)
        begin
            apb(1'b1, cmbps_pkg::OFS_TX_SELECT, 32'(1 << i));
            rd(cmbps_pkg::OFS_TX_SELECT, 32'(1 << i));
            rd(cmbps_pkg::OFS_PRIORITY, 32'h0);
            apb(1'b1, cmbps_pkg::OFS_LENGTH, {28'h0, code_t[i]});
            rd(cmbps_pkg::OFS_LENGTH, {28'h0, code_t[i]});
            apb(1'b1, cmbps_pkg::OFS_PRIORITY, {24'h0, local_priority_value_t[i]});
            rd(cmbps_pkg::OFS_PRIORITY, {24'h0, local_priority_value_t[i]});
            apb(1'b1, cmbps_pkg::OFS_STAMP_HI, 32'hFF);
            rd(cmbps_pkg::OFS_STAMP_HI, 32'h0);
        end
        $display("test load done");
        // Queue all; ties go low, smaller value wins.
        apb(1'b1, cmbps_pkg::OFS_TX_FLAG, 32'h7);
        rd(cmbps_pkg::OFS_TX_FLAG, 32'h0);
        for (k = 0; k < 3; k++)
        begin
            tx_remote <= {k[0], 2'b00};
            lm.arbitrate(ok);
            chk(ok, 1'b1);
            chk(tx_index, ord_t[k]);
            chk(tx_length_code, code_t[ord_t[k]]);
            chk(tx_byte_count, (k == 0) ? 4'h3 : ((k == 1) ? 4'h0 : 4'h8));
            lm.tick(5);
            tcount += 5;
            lm.ack(1'b1);
            gone[ord_t[k]] = 1'b1;
            rd(cmbps_pkg::OFS_TX_FLAG, {29'h0, gone});
            apb(1'b1, cmbps_pkg::OFS_TX_SELECT, 32'(1 << ord_t[k]));
            rd(cmbps_pkg::OFS_STAMP_HI, 32'(tcount >> 8));
            rd(cmbps_pkg::OFS_STAMP_LO, 32'(tcount & 255));
        end
        $display("test frames done");
        // Receive stamp, then init mode clears the timer.
        lm.tick(7);
        tcount += 7;
        lm.ack(1'b0);
        rd(cmbps_pkg::OFS_RX_STAMP, 32'(tcount));
        apb(1'b1, cmbps_pkg::OFS_CTRL, 32'h1);
        lm.tick(2);
        rd(cmbps_pkg::OFS_TIMER, 32'h0);
        chk(init_mode, 1'b1);
        $display("test receive and init done");
        print_verdict();
    end
endmodule
